/* File: verif/emr_sender_model.sv */
// emr_sender_model: hub interface A message sender, accepts requests
// assumes: delay_i sets the wait for ready; a request waits delay_i + 1 cycles
`timescale 1ns/10ps
`default_nettype none

module emr_sender_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// message request
	input wire logic msg_valid_i,
	input wire logic [3:0] delay_i,
	output logic msg_ready_o
);
	// ========
	// ready only while a request stands, after delay_i + 1 cycles
	logic [3:0] cnt_reg;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= 4'h0;
			msg_ready_o <= 1'b0;
		end else if (msg_valid_i && !msg_ready_o) begin
			msg_ready_o <= cnt_reg >= delay_i;
			cnt_reg <= cnt_reg + 4'h1;
		end else begin
			msg_ready_o <= 1'b0;
			cnt_reg <= 4'h0;
		end
	end
endmodule : emr_sender_model

`default_nettype wire

/* File: verif/emr_top_sva.sv */
// emr_top_sva: port-level checks of the error message routing block
// assumes: bound to emr_top, single clock domain on mclk_i
`timescale 1ns/10ps
`default_nettype none

module emr_top_sva (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	// events and message request
	input wire logic ev_mem_overtemp_i,
	input wire logic ev_link_a_abort_i,
	input wire logic msg_valid_o,
	input wire logic msg_is_smi_o,
	input wire logic [emr_pkg::SRC_W-1:0] msg_src_o,
	input wire logic msg_ready_i
);
	// ========
	// shadow of the smi enables, taken from completed writes
	logic [15:0] smi_sh_reg;
	wire take_w = avs_write_i && !avs_waitrequest_o &&
		avs_address_i == emr_pkg::SMI_EN_OFF;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			smi_sh_reg <= 16'h0000;
		end else begin
			if (take_w && avs_byteenable_i[0])
				smi_sh_reg[7:0] <= avs_writedata_i[7:0] &
					emr_pkg::SMI_EN_WMASK[7:0];
			if (take_w && avs_byteenable_i[1])
				smi_sh_reg[15:8] <= avs_writedata_i[15:8] &
					emr_pkg::SMI_EN_WMASK[15:8];
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	// ========
	// bus and message properties
	a_reset_quiet: assert property (
		$rose(arst_n_i) |-> !msg_valid_o && avs_waitrequest_o)
		else $error("outputs busy after reset");
	a_wait_one: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=>
		!avs_waitrequest_o) else $error("bus request not answered");
	a_wait_once: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	a_msg_hold: assert property (
		msg_valid_o && !msg_ready_i |=> msg_valid_o &&
		$stable(msg_src_o) && $stable(msg_is_smi_o))
		else $error("message request changed before accept");
	a_msg_gap: assert property (
		msg_valid_o && msg_ready_i |=> !msg_valid_o)
		else $error("no idle cycle after message");
	a_msg_kind: assert property (
		msg_valid_o |-> msg_is_smi_o ==
		(msg_src_o >= emr_pkg::FIRST_SMI_SRC))
		else $error("message kind wrong for source");
	a_src_range: assert property (
		msg_valid_o |-> msg_src_o < emr_pkg::NUM_SRC)
		else $error("message source out of range");
	a_smi_sent: assert property (
		(ev_mem_overtemp_i && smi_sh_reg[10] ||
		ev_link_a_abort_i && smi_sh_reg[6]) && !msg_valid_o |->
		##[1:2] msg_valid_o) else $error("enabled smi not requested");
endmodule : emr_top_sva

bind emr_top emr_top_sva emr_top_sva_i (.mclk_i, .arst_n_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_waitrequest_o, .ev_mem_overtemp_i,
	.ev_link_a_abort_i, .msg_valid_o, .msg_is_smi_o, .msg_src_o,
	.msg_ready_i);

`default_nettype wire

/* File: verif/error_message_routing_enables_bench.sv */
// error_message_routing_enables_bench: drives emr_top against a model
// assumes: emr_top_sva is bound, sender model answers messages
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
	num_errors++; $display("BAD t=%0t got %0h exp %0h", $time, g, e); \
	end end

module error_message_routing_enables_bench;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hF;
	logic [9:0] ev_v = 10'h000;
	logic ot_n = 1'b1;
	logic [3:0] dly = 4'h0;
	logic [31:0] rdata, rd_v;
	logic wait_s, valid, smi, ready, irq;
	logic [3:0] src;
	logic [9:0] pend = 10'h000;
	logic [4:0] serr_m = 5'h00;
	logic [15:0] smi_m = 16'h0000;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	emr_top emr_top_i (.mclk_i, .arst_n_i, .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr_s), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_s), .ev_singlebit_mem_i(ev_v[0]),
		.ev_multibit_mem_i(ev_v[1]), .ev_bad_translation_i(ev_v[2]),
		.ev_invalid_agp_i(ev_v[3]), .ev_aperture_outside_i(ev_v[4]),
		.ev_host_correctable_i(ev_v[5]), .ev_mem_overtemp_i(ev_v[6]),
		.ev_link_b_unimpl_i(ev_v[7]), .ev_link_b_abort_i(ev_v[8]),
		.ev_link_a_abort_i(ev_v[9]), .overtemp_input_n_i(ot_n),
		.msg_valid_o(valid), .msg_is_smi_o(smi), .msg_src_o(src),
		.msg_ready_i(ready), .irq_o(irq));
	emr_sender_model emr_sender_model_i (.mclk_i, .arst_n_i,
		.msg_valid_i(valid), .delay_i(dly), .msg_ready_o(ready));

	// ========
	// model of which enable governs each source
	function automatic logic en_of(input int i);
		case (i)
			5: en_of = smi_m[11];
			6: en_of = smi_m[10];
			7: en_of = smi_m[7];
			8: en_of = smi_m[8];
			9: en_of = smi_m[6];
			default: en_of = serr_m[i];
		endcase
	endfunction : en_of

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n = 0;
		@(posedge mclk_i);
		wr_s <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		be <= b;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wait_s !== 1'b0 && n < 50);
		rd_v = rdata;
		wr_s <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
		if (a == emr_pkg::SMI_EN_OFF) smi_m = d[15:0] & 16'h0DC0;
		if (a == emr_pkg::SERR_EN_OFF) serr_m = d[4:0];
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		`CHK(rd_v, e)
	endtask : rd_chk

	task automatic pulse(input logic [9:0] v);
		@(posedge mclk_i);
		ev_v <= v;
		for (int i = 0; i < 10; i++) if (v[i] && en_of(i)) pend[i] = 1'b1;
		@(posedge mclk_i);
		ev_v <= 10'h000;
	endtask : pulse

	task automatic drain;
		int n = 0;
		repeat (4) @(posedge mclk_i);
		while ((pend !== 10'h000 || valid !== 1'b0) && n < 400) begin
			@(posedge mclk_i);
			n++;
		end
		`CHK(pend, 10'h000)
	endtask : drain

	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run

	// clock and cycle ceiling
	initial forever #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles > 20000) begin
			num_errors++;
			complete_run();
		end
	end

	// every accepted message must be the lowest enabled pending one
	always @(posedge mclk_i) if (valid === 1'b1 && ready === 1'b1) begin
		`CHK(pend & ((10'h002 << src) - 10'h001), 10'h001 << src)
		`CHK(smi, src >= 4'h5)
		pend[src] = 1'b0;
	end

	initial begin
		void'($urandom(32'hC21FFD61));
		repeat (16) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		// reset values, lanes and writable bits
		rd_chk(emr_pkg::SMI_EN_OFF, 32'h0);
		rd_chk(emr_pkg::SERR_EN_OFF, 32'h0);
		bus(1'b1, emr_pkg::SMI_EN_OFF, 32'hFFFFFFFF, 4'h1);
		rd_chk(emr_pkg::SMI_EN_OFF, 32'h000000C0);
		wr(emr_pkg::SMI_EN_OFF, 32'hFFFFFFFF);
		rd_chk(emr_pkg::SMI_EN_OFF, 32'h00000DC0);
		wr(8'hE0, 32'hFFFFFFFF);
		rd_chk(8'hE0, 32'h0);
		// disabled events give status but no message
		wr(emr_pkg::SMI_EN_OFF, 32'h0);
		pulse(10'h3FF);
		drain();
		rd_chk(emr_pkg::IRQ_STAT_OFF, 32'h3FF);
		wr(emr_pkg::IRQ_STAT_OFF, 32'h3FF);
		rd_chk(emr_pkg::IRQ_STAT_OFF, 32'h0);
		// interrupt masking and clearing
		wr(emr_pkg::IRQ_MASK_OFF, 32'h8);
		pulse(10'h010);
		repeat (3) @(posedge mclk_i);
		`CHK(irq, 1'b0)
		pulse(10'h008);
		repeat (3) @(posedge mclk_i);
		`CHK(irq, 1'b1)
		wr(emr_pkg::IRQ_STAT_OFF, 32'h8);
		repeat (3) @(posedge mclk_i);
		`CHK(irq, 1'b0)
		// modelled system has ecc and host correction
		wr(emr_pkg::SERR_EN_OFF, 32'h1F);
		wr(emr_pkg::SMI_EN_OFF, 32'hDC0);
		pulse(10'h3FF);
		drain();
		// random enables, events and sender delays
		repeat (24) begin
			wr(emr_pkg::SERR_EN_OFF, $urandom);
			wr(emr_pkg::SMI_EN_OFF, $urandom);
			dly = 4'($urandom % 6);
			pulse(10'($urandom));
			drain();
		end
		// thermal trip pin, enabled then disabled
		foreach (smi_m[k]) smi_m[k] = 1'b0;
		wr(emr_pkg::SMI_EN_OFF, 32'h400);
		@(posedge mclk_i);
		ot_n <= 1'b0;
		pend[6] = 1'b1;
		drain();
		ot_n <= 1'b1;
		wr(emr_pkg::SMI_EN_OFF, 32'h0);
		@(posedge mclk_i);
		ot_n <= 1'b0;
		drain();
		complete_run();
	end
endmodule : error_message_routing_enables_bench

`default_nettype wire

/* File: verilog/emr_msg_arb.sv */
// emr_msg_arb: picks one pending error event and offers it to the
// hub interface A message sender as a valid/ready request
// assumes: pend_i is sticky until grant_o clears it
`timescale 1ns/10ps
`default_nettype none

module emr_msg_arb (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// pending events
	input wire logic [emr_pkg::NUM_SRC-1:0] pend_i,
	output logic [emr_pkg::NUM_SRC-1:0] grant_o,
	// message request
	output logic msg_valid_o,
	output logic msg_is_smi_o,
	output logic [emr_pkg::SRC_W-1:0] msg_src_o,
	input wire logic msg_ready_i
);

	// lowest pending index wins
	function automatic logic [emr_pkg::SRC_W-1:0] first_set(
		input logic [emr_pkg::NUM_SRC-1:0] v);
		logic [emr_pkg::SRC_W-1:0] idx;
		idx = '0;
		for (int i = emr_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = emr_pkg::SRC_W'(i);
			end
		end
		return idx;
	endfunction : first_set

	emr_pkg::emr_state_t state_reg;
	emr_pkg::emr_state_t state_next;
	logic [emr_pkg::SRC_W-1:0] src_reg;
	logic [emr_pkg::SRC_W-1:0] src_next;
	logic smi_reg;
	logic smi_next;
	logic [emr_pkg::NUM_SRC-1:0] grant_reg;
	logic [emr_pkg::NUM_SRC-1:0] grant_next;
	wire logic any_pend;
	wire logic [emr_pkg::SRC_W-1:0] pick;
	wire logic done;

	assign any_pend = |pend_i;
	assign pick = first_set(pend_i);
	assign done = (state_reg == emr_pkg::EMR_SEND) && msg_ready_i;

	// one request per event; clear its pending bit as the request leaves EMR_IDLE [R15]
	always_comb begin
		state_next = state_reg;
		src_next = src_reg;
		smi_next = smi_reg;
		grant_next = '0;
		case (state_reg)
			emr_pkg::EMR_IDLE: begin
				if (any_pend) begin
					state_next = emr_pkg::EMR_SEND;
					src_next = pick;
					smi_next = (pick >= emr_pkg::SRC_W'(emr_pkg::FIRST_SMI_SRC));
					grant_next[pick] = 1'b1; // [R15]
				end
			end
			emr_pkg::EMR_SEND: begin
				if (done) begin
					state_next = emr_pkg::EMR_IDLE;
				end
			end
			default: begin
				state_next = emr_pkg::EMR_IDLE;
			end
		endcase
	end

	// state and request registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= emr_pkg::EMR_IDLE;
			src_reg <= '0;
			smi_reg <= 1'b0;
			grant_reg <= '0;
		end else begin
			state_reg <= state_next;
			src_reg <= src_next;
			smi_reg <= smi_next;
			grant_reg <= grant_next;
		end
	end

	assign grant_o = grant_next;
	assign msg_valid_o = (state_reg == emr_pkg::EMR_SEND);
	assign msg_is_smi_o = smi_reg;
	assign msg_src_o = src_reg;

endmodule : emr_msg_arb

`default_nettype wire

/* File: verilog/emr_pkg.sv */
// emr_pkg: constants shared by the error message routing block
// assumes: byte-addressed 32-bit register bus, one core clock
package emr_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] SERR_EN_OFF = 8'hC8;
	localparam logic [7:0] SMI_EN_OFF = 8'hCC;
	localparam logic [7:0] IRQ_STAT_OFF = 8'hD0;
	localparam logic [7:0] IRQ_MASK_OFF = 8'hD4;

	// ==========================================================
	// reset values
	localparam logic [4:0] SERR_EN_RST = 5'h00;
	localparam logic [15:0] SMI_EN_RST = 16'h0000;
	localparam logic [9:0] IRQ_STAT_RST = 10'h000;
	localparam logic [9:0] IRQ_MASK_RST = 10'h000;

	// ==========================================================
	// serr enable bit positions
	localparam int SERR_SINGLEBIT_BIT = 0;
	localparam int SERR_MULTIBIT_BIT = 1;
	localparam int SERR_BAD_XLAT_BIT = 2;
	localparam int SERR_INVALID_AGP_BIT = 3;
	localparam int SERR_APERTURE_BIT = 4;

	// ==========================================================
	// smi enable bit positions and writable bits
	localparam int SMI_LINK_A_ABORT_BIT = 6;
	localparam int SMI_LINK_B_UNIMPL_BIT = 7;
	localparam int SMI_LINK_B_ABORT_BIT = 8;
	localparam int SMI_THERMAL_BIT = 10;
	localparam int SMI_HOST_CORR_BIT = 11;
	localparam logic [15:0] SMI_EN_WMASK = 16'h0DC0;

	// ==========================================================
	// event source indices, also status and mask bit positions
	localparam int NUM_SRC = 10;
	localparam int SRC_W = 4;
	localparam int SRC_SINGLEBIT = 0;
	localparam int SRC_MULTIBIT = 1;
	localparam int SRC_BAD_XLAT = 2;
	localparam int SRC_INVALID_AGP = 3;
	localparam int SRC_APERTURE = 4;
	localparam int SRC_HOST_CORR = 5;
	localparam int SRC_THERMAL = 6;
	localparam int SRC_LINK_B_UNIMPL = 7;
	localparam int SRC_LINK_B_ABORT = 8;
	localparam int SRC_LINK_A_ABORT = 9;
	localparam int FIRST_SMI_SRC = 5;

	// ==========================================================
	// message sender states
	typedef enum logic [1:0] {
		EMR_IDLE = 2'b01,
		EMR_SEND = 2'b10
	} emr_state_t;

endpackage : emr_pkg

/* File: verilog/emr_top.sv */
// emr_top: error message routing enables of the memory hub; turns
// detected error events into serr or smi message requests for the
// hub interface A sender, with enables and interrupts on avalon-mm
// assumes: ev_*_i are one-cycle pulses on mclk_i, overtemp_input_n_i
// is an asynchronous pin, the sender answers with msg_ready_i
//
// Summary of operation
// [R1] aperture-outside access sends serr when enabled
// [R2] invalid agp access sends serr when enabled
// [R3] bad translation entry sends serr when enabled
// [R4] multibit memory error sends serr when enabled
// [R5] singlebit memory error sends serr when enabled
// [R6] software keeps memory serr enables clear without ecc
// [R7] 16-bit smi enable register, resets to zero
// [R8] software enables one message kind per error
// [R9] host correctable error sends smi when enabled
// [R10] software clears host smi without host correction
// [R11] thermal trip edge sends smi when enabled
// [R12] link b target abort sends smi when enabled
// [R13] link b unimplemented cycle sends smi when enabled
// [R14] link a target abort sends smi when enabled
// [R15] each enabled event gives exactly one request
`timescale 1ns/10ps
`default_nettype none

module emr_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// error events, one-cycle pulses
	input wire logic ev_singlebit_mem_i,
	input wire logic ev_multibit_mem_i,
	input wire logic ev_bad_translation_i,
	input wire logic ev_invalid_agp_i,
	input wire logic ev_aperture_outside_i,
	input wire logic ev_host_correctable_i,
	input wire logic ev_mem_overtemp_i,
	input wire logic ev_link_b_unimpl_i,
	input wire logic ev_link_b_abort_i,
	input wire logic ev_link_a_abort_i,
	// thermal trip pin, active low
	input wire logic overtemp_input_n_i,
	// hub interface A message request
	output logic msg_valid_o,
	output logic msg_is_smi_o,
	output logic [emr_pkg::SRC_W-1:0] msg_src_o,
	input wire logic msg_ready_i,
	// interrupt
	output logic irq_o
);

	// ==========================================================
	// helpers

	// address match for a register offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// byte-lane merge of write data into a 32-bit value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ==========================================================
	// registers

	logic [4:0] serr_en_reg;
	logic [4:0] serr_en_next;
	logic [15:0] smi_en_reg;
	logic [15:0] smi_en_next;
	logic [emr_pkg::NUM_SRC-1:0] stat_reg;
	logic [emr_pkg::NUM_SRC-1:0] stat_next;
	logic [emr_pkg::NUM_SRC-1:0] mask_reg;
	logic [emr_pkg::NUM_SRC-1:0] mask_next;
	logic [emr_pkg::NUM_SRC-1:0] pend_reg;
	logic [emr_pkg::NUM_SRC-1:0] pend_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wait_reg;
	logic wait_next;
	logic irq_reg;
	logic irq_next;
	logic ovt_s1_reg;
	logic ovt_s2_reg;
	logic ovt_prev_reg;

	// ==========================================================
	// bus decode

	wire logic req;
	wire logic commit;
	wire logic wr_commit;
	wire logic sel_serr;
	wire logic sel_smi;
	wire logic sel_stat;
	wire logic sel_mask;
	wire logic [31:0] serr_word;
	wire logic [31:0] smi_word;
	wire logic [31:0] stat_word;
	wire logic [31:0] mask_word;
	wire logic [31:0] wr_serr;
	wire logic [31:0] wr_smi;
	wire logic [31:0] wr_stat;
	wire logic [31:0] wr_mask;

	// request is answered in the cycle after it is seen
	assign req = avs_read_i | avs_write_i;
	assign commit = req & ~wait_reg;
	assign wr_commit = commit & avs_write_i;
	assign sel_serr = hit(avs_address_i, emr_pkg::SERR_EN_OFF);
	assign sel_smi = hit(avs_address_i, emr_pkg::SMI_EN_OFF);
	assign sel_stat = hit(avs_address_i, emr_pkg::IRQ_STAT_OFF);
	assign sel_mask = hit(avs_address_i, emr_pkg::IRQ_MASK_OFF);

	// register words as seen on the bus, upper bits zero
	assign serr_word = {27'h0000000, serr_en_reg};
	assign smi_word = {16'h0000, smi_en_reg};
	assign stat_word = {22'h000000, stat_reg};
	assign mask_word = {22'h000000, mask_reg};

	// merged write values per register
	assign wr_serr = merge(serr_word, avs_writedata_i, avs_byteenable_i);
	assign wr_smi = merge(smi_word, avs_writedata_i, avs_byteenable_i);
	assign wr_stat = merge(32'h00000000, avs_writedata_i, avs_byteenable_i);
	assign wr_mask = merge(mask_word, avs_writedata_i, avs_byteenable_i);

	// ==========================================================
	// thermal pin synchroniser and edge detect

	wire logic ovt_rise;

	// two flops before use, then compare with previous level
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovt_s1_reg <= 1'b1;
			ovt_s2_reg <= 1'b1;
			ovt_prev_reg <= 1'b1;
		end else begin
			ovt_s1_reg <= overtemp_input_n_i;
			ovt_s2_reg <= ovt_s1_reg;
			ovt_prev_reg <= ovt_s2_reg;
		end
	end

	// trip condition rises when the low-active pin falls
	assign ovt_rise = ovt_prev_reg & ~ovt_s2_reg; // [R11]

	// ==========================================================
	// event vector and enables

	wire logic [emr_pkg::NUM_SRC-1:0] ev;
	wire logic [emr_pkg::NUM_SRC-1:0] en;
	wire logic [emr_pkg::NUM_SRC-1:0] route;
	wire logic [emr_pkg::NUM_SRC-1:0] grant;

	assign ev[emr_pkg::SRC_SINGLEBIT] = ev_singlebit_mem_i;
	assign ev[emr_pkg::SRC_MULTIBIT] = ev_multibit_mem_i;
	assign ev[emr_pkg::SRC_BAD_XLAT] = ev_bad_translation_i;
	assign ev[emr_pkg::SRC_INVALID_AGP] = ev_invalid_agp_i;
	assign ev[emr_pkg::SRC_APERTURE] = ev_aperture_outside_i;
	assign ev[emr_pkg::SRC_HOST_CORR] = ev_host_correctable_i;
	assign ev[emr_pkg::SRC_THERMAL] = ovt_rise | ev_mem_overtemp_i; // [R11]
	assign ev[emr_pkg::SRC_LINK_B_UNIMPL] = ev_link_b_unimpl_i;
	assign ev[emr_pkg::SRC_LINK_B_ABORT] = ev_link_b_abort_i;
	assign ev[emr_pkg::SRC_LINK_A_ABORT] = ev_link_a_abort_i;

	// serr enables gate the memory and agp sources
	assign en[emr_pkg::SRC_SINGLEBIT] =
		serr_en_reg[emr_pkg::SERR_SINGLEBIT_BIT]; // [R5]
	assign en[emr_pkg::SRC_MULTIBIT] =
		serr_en_reg[emr_pkg::SERR_MULTIBIT_BIT]; // [R4]
	assign en[emr_pkg::SRC_BAD_XLAT] =
		serr_en_reg[emr_pkg::SERR_BAD_XLAT_BIT]; // [R3]
	assign en[emr_pkg::SRC_INVALID_AGP] =
		serr_en_reg[emr_pkg::SERR_INVALID_AGP_BIT]; // [R2]
	assign en[emr_pkg::SRC_APERTURE] =
		serr_en_reg[emr_pkg::SERR_APERTURE_BIT]; // [R1]

	// smi enables gate the host, thermal and link sources
	assign en[emr_pkg::SRC_HOST_CORR] =
		smi_en_reg[emr_pkg::SMI_HOST_CORR_BIT]; // [R9]
	assign en[emr_pkg::SRC_THERMAL] =
		smi_en_reg[emr_pkg::SMI_THERMAL_BIT]; // [R11]
	assign en[emr_pkg::SRC_LINK_B_UNIMPL] =
		smi_en_reg[emr_pkg::SMI_LINK_B_UNIMPL_BIT]; // [R13]
	assign en[emr_pkg::SRC_LINK_B_ABORT] =
		smi_en_reg[emr_pkg::SMI_LINK_B_ABORT_BIT]; // [R12]
	assign en[emr_pkg::SRC_LINK_A_ABORT] =
		smi_en_reg[emr_pkg::SMI_LINK_A_ABORT_BIT]; // [R14]

	// disabled events are dropped, enabled ones become pending
	assign route = ev & en; // [R15]

	// ==========================================================
	// next-state logic

	// enable registers; reserved smi bits stay zero [R7]
	assign serr_en_next = (wr_commit && sel_serr) ? wr_serr[4:0] : serr_en_reg;
	assign smi_en_next = (wr_commit && sel_smi) ?
		(wr_smi[15:0] & emr_pkg::SMI_EN_WMASK) : smi_en_reg; // [R7]
	assign mask_next = (wr_commit && sel_mask) ?
		wr_mask[emr_pkg::NUM_SRC-1:0] : mask_reg;

	// sticky status: write one to clear, a new event wins
	assign stat_next = (stat_reg &
		~((wr_commit && sel_stat) ? wr_stat[emr_pkg::NUM_SRC-1:0] :
		{emr_pkg::NUM_SRC{1'b0}})) | ev;

	// pending requests: grant clears, a new enabled event wins [R15]
	assign pend_next = (pend_reg & ~grant) | route;

	// waitrequest low for exactly one cycle per request
	assign wait_next = ~(req & wait_reg);

	// read data captured while the request waits
	assign rdata_next = (req && wait_reg && avs_read_i) ?
		((sel_serr ? serr_word : 32'h00000000) |
		(sel_smi ? smi_word : 32'h00000000) |
		(sel_stat ? stat_word : 32'h00000000) |
		(sel_mask ? mask_word : 32'h00000000)) : rdata_reg;

	// level interrupt from unmasked status
	assign irq_next = |(stat_next & mask_next);

	// ==========================================================
	// register update

	// software-visible registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serr_en_reg <= emr_pkg::SERR_EN_RST;
			smi_en_reg <= emr_pkg::SMI_EN_RST; // [R7]
			stat_reg <= emr_pkg::IRQ_STAT_RST;
			mask_reg <= emr_pkg::IRQ_MASK_RST;
		end else begin
			serr_en_reg <= serr_en_next;
			smi_en_reg <= smi_en_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
		end
	end

	// internal and bus-answer registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_reg <= '0;
			rdata_reg <= 32'h00000000;
			wait_reg <= 1'b1;
			irq_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
			irq_reg <= irq_next;
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign irq_o = irq_reg;

	// ==========================================================
	// message request toward the hub interface A sender

	emr_msg_arb u_arb (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.pend_i(pend_reg),
		.grant_o(grant),
		.msg_valid_o(msg_valid_o),
		.msg_is_smi_o(msg_is_smi_o),
		.msg_src_o(msg_src_o),
		.msg_ready_i(msg_ready_i)
	);

endmodule : emr_top

`default_nettype wire
